// ==== rtl/compact_timer_pkg.sv ====
// Register map, field positions and reset values of the compact timer
package compact_timer_pkg;
    localparam logic [7:0] CTRL0_OFFSET     = 8'h00;
    localparam logic [7:0] CTRL1_OFFSET     = 8'h04;
    localparam logic [7:0] COUNT_OFFSET     = 8'h08;
    localparam logic [7:0] COMPARE_A_OFFSET = 8'h0c;
    localparam logic [7:0] PERIOD_OFFSET    = 8'h10;
    localparam logic [7:0] FLAGS_OFFSET     = 8'h14;
    localparam int ON_BIT         = 3;
    localparam int MODE_MSB       = 7;
    localparam int MODE_LSB       = 6;
    localparam int FUNC_MSB       = 5;
    localparam int FUNC_LSB       = 4;
    localparam int INIT_LEVEL_BIT = 3;
    localparam int INVERT_BIT     = 2;
    localparam int SWAP_BIT       = 1;
    localparam int CLEAR_SEL_BIT  = 0;
    localparam int FLAG_A_BIT     = 0;
    localparam int FLAG_P_BIT     = 1;
    localparam logic [7:0]  CTRL1_RESET     = 8'h00;
    localparam logic [15:0] COMPARE_A_RESET = 16'h0000;
    localparam logic [7:0]  PERIOD_RESET    = 8'h00;
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM     = 2'h2;
    localparam logic [1:0] MODE_TIMER   = 2'h3;
    localparam logic [1:0] FUNC_NONE    = 2'h0;
    localparam logic [1:0] FUNC_LOW     = 2'h1;
    localparam logic [1:0] FUNC_HIGH    = 2'h2;
    localparam logic [1:0] FUNC_TOGGLE  = 2'h3;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// ==== rtl/compact_timer.sv ====
// Compact 16-bit timer with two comparators and PWM, AXI4-Lite registers
module compact_timer
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        tick,
    output logic             timer_out,
    output logic             timer_out_en
);
    logic        counter_on_q;
    logic        on_prev_q;
    logic [7:0]  ctrl1_q;
    logic [15:0] compare_a_value_q;
    logic [7:0]  period_compare_byte_q;
    logic [15:0] count_q;
    logic        match_a_flag_q;
    logic        match_p_flag_q;
    logic        pin_q;
    logic        pwm_level_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    logic [1:0]  mode;
    logic [1:0]  func;
    logic        clear_select;
    logic        init_level;
    logic        output_invert;
    logic        period_duty_swap;
    logic        on_rise;
    logic        running;
    logic        hit_a;
    logic        hit_p;
    logic        flag_a_evt;
    logic        flag_p_evt;
    logic        clear_cnt;
    logic [16:0] scaled_p;
    logic [16:0] period_len;
    logic [16:0] duty_len;
    logic        wr_fire;
    logic        wr_bank;
    logic        clr_a;
    logic        clr_p;
    logic [15:0] next_count;

    // Period byte times 256 as a length, zero meaning 65536
    function automatic logic [16:0] scale_period(input logic [7:0] value);
        if (value == 8'h00)
        begin
            return 17'h10000;
        end
        return {1'b0, value, 8'h00};
    endfunction

    // Apply byte strobes to an 8-bit wide lane
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
        return strb[0] ? data[7:0] : old;
    endfunction

    assign mode             = ctrl1_q[compact_timer_pkg::MODE_MSB:compact_timer_pkg::MODE_LSB];
    assign func             = ctrl1_q[compact_timer_pkg::FUNC_MSB:compact_timer_pkg::FUNC_LSB];
    assign init_level       = ctrl1_q[compact_timer_pkg::INIT_LEVEL_BIT];
    assign output_invert    = ctrl1_q[compact_timer_pkg::INVERT_BIT];
    assign period_duty_swap = ctrl1_q[compact_timer_pkg::SWAP_BIT];
    assign clear_select     = ctrl1_q[compact_timer_pkg::CLEAR_SEL_BIT];
    assign on_rise          = counter_on_q && !on_prev_q;
    assign running          = counter_on_q && on_prev_q && tick;

    // Comparators fire when the counter reaches a nonzero compare point
    assign hit_p = running && (count_q[15:8] == period_compare_byte_q)
                   && (count_q[7:0] == 8'h00) && (period_compare_byte_q != 8'h00);
    assign hit_a = running && (count_q == compare_a_value_q)
                   && (compare_a_value_q != 16'h0000);

    assign scaled_p   = scale_period(period_compare_byte_q);
    assign period_len = period_duty_swap ? {1'b0, compare_a_value_q} : scaled_p;
    assign duty_len   = period_duty_swap ? scaled_p : {1'b0, compare_a_value_q};

    always_comb
    begin
        flag_a_evt = hit_a;
        flag_p_evt = hit_p;
        clear_cnt  = 1'b0;
        if (mode == compact_timer_pkg::MODE_PWM)
        begin
            // Clear select ignored, period source clears the counter
            clear_cnt = running && ({1'b0, count_q} + 17'h00001 >= period_len)
                        && (period_len != 17'h00000);
            // Counter may wrap before reaching a compare point, so match on its last count
            flag_a_evt = hit_a || (running
                         && ({1'b0, count_q} + 17'h00001 == {1'b0, compare_a_value_q}));
            flag_p_evt = hit_p || (running
                         && ({1'b0, count_q} + 17'h00001 == scaled_p));
        end
        else if (clear_select)
        begin
            flag_p_evt = 1'b0;
            clear_cnt  = hit_a;
        end
        else
        begin
            clear_cnt = hit_p;
        end
    end

    assign next_count = clear_cnt ? 16'h0000 : count_q + 16'h0001;

    // Counter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_q   <= 16'h0000;
            on_prev_q <= 1'b0;
        end
        else
        begin
            on_prev_q <= counter_on_q;
            if (on_rise)
            begin
                count_q <= 16'h0000;
            end
            else if (running)
            begin
                count_q <= next_count;
            end
        end
    end

    // PWM active phase, restarted at each period start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_level_q <= 1'b0;
        end
        else if (on_rise)
        begin
            pwm_level_q <= (duty_len != 17'h00000);
        end
        else if (running)
        begin
            if (clear_cnt)
            begin
                pwm_level_q <= (duty_len != 17'h00000);
            end
            else if (duty_len < period_len)
            begin
                pwm_level_q <= ({1'b0, next_count} < duty_len);
            end
            else
            begin
                pwm_level_q <= 1'b1;
            end
        end
    end

    // Output pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_q        <= 1'b0;
            timer_out    <= 1'b0;
            timer_out_en <= 1'b0;
        end
        else
        begin
            if (mode == compact_timer_pkg::MODE_COMPARE)
            begin
                if (on_rise)
                begin
                    pin_q <= init_level;
                end
                else if (hit_a)
                begin
                    case (func)
                        compact_timer_pkg::FUNC_LOW:    pin_q <= 1'b0;
                        compact_timer_pkg::FUNC_HIGH:   pin_q <= 1'b1;
                        compact_timer_pkg::FUNC_TOGGLE: pin_q <= !pin_q;
                        default:                        pin_q <= pin_q;
                    endcase
                end
                timer_out <= pin_q ^ output_invert;
            end
            else if (mode == compact_timer_pkg::MODE_PWM)
            begin
                case (func)
                    compact_timer_pkg::FUNC_NONE: timer_out <= !init_level ^ output_invert;
                    compact_timer_pkg::FUNC_LOW:  timer_out <= init_level ^ output_invert;
                    compact_timer_pkg::FUNC_HIGH:
                        timer_out <= (pwm_level_q ~^ init_level) ^ output_invert;
                    default:                      timer_out <= !init_level ^ output_invert;
                endcase
            end
            else
            begin
                timer_out <= 1'b0;
            end
            timer_out_en <= (mode == compact_timer_pkg::MODE_COMPARE)
                            || (mode == compact_timer_pkg::MODE_PWM);
        end
    end

    // Write channel capture
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_bank = wr_fire && (awaddr_q == compact_timer_pkg::FLAGS_OFFSET);
    assign clr_a   = wr_bank && wstrb_q[0] && wdata_q[compact_timer_pkg::FLAG_A_BIT];
    assign clr_p   = wr_bank && wstrb_q[0] && wdata_q[compact_timer_pkg::FLAG_P_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= compact_timer_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_q)
                    compact_timer_pkg::CTRL0_OFFSET, compact_timer_pkg::CTRL1_OFFSET,
                    compact_timer_pkg::COUNT_OFFSET, compact_timer_pkg::COMPARE_A_OFFSET,
                    compact_timer_pkg::PERIOD_OFFSET, compact_timer_pkg::FLAGS_OFFSET:
                        s_axi_bresp <= compact_timer_pkg::RESP_OKAY;
                    default: s_axi_bresp <= compact_timer_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            counter_on_q          <= 1'b0;
            ctrl1_q               <= compact_timer_pkg::CTRL1_RESET;
            compare_a_value_q     <= compact_timer_pkg::COMPARE_A_RESET;
            period_compare_byte_q <= compact_timer_pkg::PERIOD_RESET;
        end
        else if (wr_fire)
        begin
            case (awaddr_q)
                compact_timer_pkg::CTRL0_OFFSET:
                    if (wstrb_q[0])
                    begin
                        counter_on_q <= wdata_q[compact_timer_pkg::ON_BIT];
                    end
                compact_timer_pkg::CTRL1_OFFSET:
                    ctrl1_q <= lane0(ctrl1_q, wdata_q, wstrb_q);
                compact_timer_pkg::COMPARE_A_OFFSET:
                begin
                    compare_a_value_q[7:0]  <= lane0(compare_a_value_q[7:0], wdata_q, wstrb_q);
                    if (wstrb_q[1])
                    begin
                        compare_a_value_q[15:8] <= wdata_q[15:8];
                    end
                end
                compact_timer_pkg::PERIOD_OFFSET:
                    period_compare_byte_q <= lane0(period_compare_byte_q, wdata_q, wstrb_q);
                default:
                begin
                end
            endcase
        end
    end

    // Sticky flags, an event wins over a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            match_a_flag_q <= 1'b0;
            match_p_flag_q <= 1'b0;
        end
        else
        begin
            match_a_flag_q <= flag_a_evt || (match_a_flag_q && !clr_a);
            match_p_flag_q <= flag_p_evt || (match_p_flag_q && !clr_p);
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= compact_timer_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= compact_timer_pkg::RESP_OKAY;
                s_axi_rdata  <= 32'h00000000;
                case (s_axi_araddr)
                    compact_timer_pkg::CTRL0_OFFSET:
                        s_axi_rdata[compact_timer_pkg::ON_BIT] <= counter_on_q;
                    compact_timer_pkg::CTRL1_OFFSET:     s_axi_rdata[7:0]  <= ctrl1_q;
                    compact_timer_pkg::COUNT_OFFSET:     s_axi_rdata[15:0] <= count_q;
                    compact_timer_pkg::COMPARE_A_OFFSET: s_axi_rdata[15:0] <= compare_a_value_q;
                    compact_timer_pkg::PERIOD_OFFSET:    s_axi_rdata[7:0]  <= period_compare_byte_q;
                    compact_timer_pkg::FLAGS_OFFSET:
                        s_axi_rdata[1:0] <= {match_p_flag_q, match_a_flag_q};
                    default: s_axi_rresp <= compact_timer_pkg::RESP_SLVERR;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ==== verification/pin_load.sv ====
// Output pin load: pulled-up pin with a counter of high cycles
module pin_load
(
    input  wire logic aclk,
    input  wire logic drive,
    input  wire logic drive_en,
    input  wire logic clr,
    output logic      level,
    output int        high_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // Released pin floats to the pull-up level
    assign level = drive_en ? drive : 1'b1;
    always_ff @(posedge aclk)
    begin
        if (clr)
            high_cnt <= 0;
        else if (level)
            high_cnt <= high_cnt + 1;
    end
endmodule

// ==== verification/compact_timer_chk.sv ====
// Port-level assertions for the compact timer
module compact_timer_chk
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        timer_out,
    input wire logic        timer_out_en
);
    logic [7:0] c1_q;
    logic       on_q;
    logic       wr_go;
    logic       is_tmr;
    logic       is_pwm;
    logic       is_cmp;
    assign wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign is_tmr = c1_q[7:6] == compact_timer_pkg::MODE_TIMER;
    assign is_pwm = c1_q[7:6] == compact_timer_pkg::MODE_PWM;
    assign is_cmp = c1_q[7:6] == compact_timer_pkg::MODE_COMPARE;
    // Shadow copies of the control registers, snooped from the bus
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            c1_q <= 8'h00;
        else if (wr_go && s_axi_awaddr == compact_timer_pkg::CTRL1_OFFSET)
            c1_q <= s_axi_wdata[7:0];
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            on_q <= 1'b0;
        else if (wr_go && s_axi_awaddr == compact_timer_pkg::CTRL0_OFFSET)
            on_q <= s_axi_wdata[compact_timer_pkg::ON_BIT];
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_tmr_en; is_tmr [*3] |-> !timer_out_en; endproperty
    a_tmr_en: assert property (p_tmr_en) else $error("Pin enabled in timer mode");
    property p_pwm_en; is_pwm [*3] |-> timer_out_en; endproperty
    a_pwm_en: assert property (p_pwm_en) else $error("Pin idle in pwm mode");
    property p_pwm_off;
        (is_pwm && on_q && c1_q[5:4] == 2'h0) [*4] |-> timer_out == (!c1_q[3] ^ c1_q[2]);
    endproperty
    a_pwm_off: assert property (p_pwm_off) else $error("Forced inactive wrong");
    property p_pwm_act;
        (is_pwm && on_q && c1_q[5:4] == 2'h1) [*4] |-> timer_out == (c1_q[3] ^ c1_q[2]);
    endproperty
    a_pwm_act: assert property (p_pwm_act) else $error("Forced active wrong");
    property p_cmp_hold;
        (is_cmp && on_q && c1_q[5:4] == 2'h0) [*5] |-> $stable(timer_out);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("Pin moved with no function");
    property p_on_init;
        $rose(on_q) && is_cmp |-> ##4 timer_out == (c1_q[3] ^ c1_q[2]);
    endproperty
    a_on_init: assert property (p_on_init) else $error("Pin not at initial level");
    property p_b_after; wr_go |-> ##[1:3] s_axi_bvalid; endproperty
    a_b_after: assert property (p_b_after) else $error("Write response missing");
    property p_r_after; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
    a_r_after: assert property (p_r_after) else $error("Read data missing");
endmodule

bind compact_timer compact_timer_chk compact_timer_chk_inst
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .timer_out, .timer_out_en
);

// ==== verification/compact_timer_tb.sv ====
// Self-checking bench for the compact timer
module compact_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CTL0 = compact_timer_pkg::CTRL0_OFFSET;
    localparam logic [7:0] CTL1 = compact_timer_pkg::CTRL1_OFFSET;
    localparam logic [7:0] CNT  = compact_timer_pkg::COUNT_OFFSET;
    localparam logic [7:0] CMPA = compact_timer_pkg::COMPARE_A_OFFSET;
    localparam logic [7:0] PER  = compact_timer_pkg::PERIOD_OFFSET;
    localparam logic [7:0] FLG  = compact_timer_pkg::FLAGS_OFFSET;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        timer_out;
    logic        timer_out_en;
    logic        clr;
    logic        level;
    int          high_cnt;
    int          err_count;
    int          samples_checked;
    logic [31:0] rdv;
    logic [1:0]  resp;

    compact_timer compact_timer_inst
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .tick(1'b1), .timer_out,
        .timer_out_en
    );
    pin_load pin_load_inst
    (
        .aclk, .drive(timer_out), .drive_en(timer_out_en), .clr, .level, .high_cnt
    );

    always #5 aclk = ~aclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && n < 40);
        if (s_axi_bvalid !== 1'b1)
            err_count++;
        resp = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && n < 40);
        if (s_axi_rvalid !== 1'b1)
            err_count++;
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Stop, configure, clear flags, restart from zero
    task automatic start(input logic [7:0] c1);
        wr(CTL0, 32'h0);
        wr(CTL1, {24'h0, c1});
        wr(FLG, 32'h3);
        wr(CTL0, 32'h8);
    endtask

    // Active cycles of the pin over a window, after settling
    task automatic measure(input int win, input int exp);
        clr <= 1'b1;
        repeat (20) @(posedge aclk);
        clr <= 1'b0;
        repeat (win + 1) @(posedge aclk);
        chk("active cycles", 32'(high_cnt), 32'(exp));
    endtask

    task automatic test_regs();
        logic [7:0] addrs [4] = '{CTL1, CMPA, PER, FLG};
        foreach (addrs[i])
        begin
            rd(addrs[i]);
            chk("reset value", rdv, 32'h0);
        end
        wr(PER, 32'ha5);
        rd(PER);
        chk("period readback", rdv, 32'ha5);
        wr(8'h18, 32'h1);
        chk("unmapped write", 32'(resp), 32'(compact_timer_pkg::RESP_SLVERR));
        rd(8'h18);
        chk("unmapped read", 32'(resp), 32'(compact_timer_pkg::RESP_SLVERR));
        $display("registers test done");
    endtask

    task automatic test_cmp();
        logic [1:0] f;
        logic       ini;
        logic       exp;
        wr(PER, 32'h1);
        wr(CMPA, 32'h40);
        for (int i = 0; i < 4; i++)
        begin
            f = 2'(i);
            ini = (f != 2'h2);
            exp = f[1] ? (f[0] ? !ini : 1'b1) : (f[0] ? 1'b0 : ini);
            start({2'h0, f, ini, 3'h0});
            repeat (10) @(posedge aclk);
            chk("pin initial", 32'(level), 32'(ini));
            repeat (270) @(posedge aclk);
            chk("pin after match", 32'(level), 32'(exp));
            rd(FLG);
            chk("compare flags", rdv, 32'h3);
            rd(CNT);
            chk("counter high bits", rdv & 32'hffffff00, 32'h0);
        end
        $display("compare test done");
    endtask

    task automatic test_clear_a();
        wr(CMPA, 32'h200);
        start(8'h01);
        repeat (700) @(posedge aclk);
        rd(FLG);
        chk("flags clear on A", rdv, 32'h1);
        rd(CNT);
        chk("count within A", 32'(rdv <= 32'h200), 32'h1);
        wr(CMPA, 32'h0);
        start(8'h01);
        repeat (300) @(posedge aclk);
        rd(FLG);
        chk("flags A zero", rdv, 32'h0);
        $display("clear on A test done");
    endtask

    task automatic test_pwm();
        int hi;
        wr(CMPA, 32'h40);
        for (int f = 0; f < 3; f++)
            for (int v = 0; v < 2; v++)
            begin
                start({2'h2, 2'(f), 1'b1, 1'(v), 1'b0, 1'(v)});
                hi = (f == 0) ? 0 : ((f == 1) ? 256 : 64);
                measure(256, (v == 1) ? 256 - hi : hi);
                rd(FLG);
                chk("pwm flags", rdv, 32'h3);
            end
        wr(CMPA, 32'h100);
        start(8'haa);
        measure(256, 256);
        wr(CMPA, 32'h200);
        start(8'haa);
        measure(512, 256);
        $display("pwm test done");
    endtask

    task automatic test_tmr();
        wr(CMPA, 32'h40);
        start(8'hc0);
        rd(CNT);
        chk("counter restart", 32'(rdv < 32'h10), 32'h1);
        repeat (300) @(posedge aclk);
        chk("timer pin enable", 32'(timer_out_en), 32'h0);
        rd(FLG);
        chk("timer flags", rdv, 32'h3);
        $display("timer test done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #300000;
        err_count++;
        results();
    end

    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wvalid = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        clr = 1'b1;
        err_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        test_regs();
        test_cmp();
        test_clear_a();
        test_pwm();
        test_tmr();
        results();
    end
endmodule
